/* design/cpu_address_arithmetic.v */
// Address generation datapath: address source select, adders and virtual address latch
//
// Contract
// - Adder operands are chosen by the three mode bits of the instruction register and by the indirect read cycle code.
// - The memory cycle kind comes from microinstruction register bits 21 to 23.
// - A fetch uses the program counter as address and increments it by one.
// - Every non-fetch reference gets its address from two adders with selectors.
// - Fetch, operand read and indirect read are reads, store is a write; only fetch steps the counter.
// - Entering fetch loads the counter into the address latch and raises a request.
// - A fetched word goes into both the instruction and holding registers.
// - With no mode bits set the address is counter plus sign-extended displacement.
// - Indirect mode makes two memory references, indirect address then operand.
// - With base pre-indexing and indirection the first address is base plus displacement.
// - The word read by the indirect cycle is captured in the holding register.
// - With indirection and post-indexing the operand address is the holding register plus the index register.
// - Bit 10 is post-index, bit 9 indirect, bit 8 pre-index, bits 0 to 7 the displacement.
// - The displacement is sign extended over the range -128 to +127.
// - Indexing adds no cycles; only indirection adds one memory cycle.
`timescale 1ns/1ps
`include "addr_arith_map.vh"
module cpu_address_arithmetic (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Microprogram control
    input wire [23:0] microinstruction_register,
    input wire cycle_start,
    // Register file operands
    input wire [15:0] index_reg,
    input wire [15:0] base_reg,
    // Memory interface
    input wire mem_done,
    input wire [15:0] mem_rdata,
    output reg [15:0] virt_addr,
    output reg mem_req,
    output reg mem_write,
    // Datapath state to the rest of the CPU
    output reg [15:0] program_counter,
    output reg [15:0] instr_reg,
    output reg [15:0] hold_reg,
    output reg [2:0] cycle_kind,
    output reg busy
);
    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg state_q;
    wire [2:0] cyc_sel;
    wire post_x;
    wire ind;
    wire pre_b;
    wire [15:0] disp_ext;
    wire cyc_valid;
    assign cyc_sel = microinstruction_register[`MIR_CYC_MSB:`MIR_CYC_LSB];
    assign post_x = instr_reg[`IR_POST_X_BIT];
    assign ind = instr_reg[`IR_IND_BIT];
    assign pre_b = instr_reg[`IR_PRE_B_BIT];
    assign disp_ext = {{8{instr_reg[`IR_DISP_SIGN]}}, instr_reg[`IR_DISP_MSB:`IR_DISP_LSB]};
    assign cyc_valid = (cyc_sel == `CYC_FETCH) || (cyc_sel == `CYC_OPREAD) ||
                       (cyc_sel == `CYC_INDREAD) || (cyc_sel == `CYC_STORE);

    // ------------------------------------------------------------
    // Address arithmetic: two adders with input selectors
    // ------------------------------------------------------------
    // First adder forms the pre-indexed address, the second adds X after
    // an optional indirection so X indexing costs no extra cycle.
    reg [15:0] a1_base;
    reg [15:0] a2_a;
    reg [15:0] a2_b;
    wire [15:0] sum1;
    wire [15:0] sum2;

    always @* begin
        a1_base = pre_b ? base_reg : program_counter;
        if (cyc_sel == `CYC_INDREAD) begin
            a2_a = sum1;
            a2_b = `RST_WORD;
        end else if (ind) begin
            a2_a = hold_reg;
            a2_b = post_x ? index_reg : `RST_WORD;
        end else begin
            a2_a = sum1;
            a2_b = post_x ? index_reg : `RST_WORD;
        end
    end

    addr_adder u_pre (
        .a(a1_base),
        .b(disp_ext),
        .sum(sum1)
    );

    addr_adder u_post (
        .a(a2_a),
        .b(a2_b),
        .sum(sum2)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire start_ok;
    wire start_fetch;
    wire start_store;
    wire load_ir;
    wire load_hold;
    // Starts are ignored while busy so the latch cannot move under a request.
    assign start_ok = (state_q == ST_IDLE) && cycle_start && cyc_valid;
    assign start_fetch = start_ok && (cyc_sel == `CYC_FETCH);
    assign start_store = start_ok && (cyc_sel == `CYC_STORE);
    // Fetch fills both registers; either read fills the holding register
    assign load_ir = (state_q == ST_WAIT) && mem_done && (cycle_kind == `CYC_FETCH);
    assign load_hold = (state_q == ST_WAIT) && mem_done &&
                       ((cycle_kind == `CYC_FETCH) || (cycle_kind == `CYC_INDREAD) ||
                        (cycle_kind == `CYC_OPREAD));

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    reg state_d;
    reg [15:0] virt_addr_d;
    reg mem_req_d;
    reg mem_write_d;
    reg [15:0] program_counter_d;
    reg [15:0] instr_reg_d;
    reg [15:0] hold_reg_d;
    reg [2:0] cycle_kind_d;
    reg busy_d;

    always @* begin
        state_d = state_q;
        virt_addr_d = virt_addr;
        mem_req_d = mem_req;
        mem_write_d = mem_write;
        program_counter_d = program_counter;
        cycle_kind_d = cycle_kind;
        busy_d = busy;
        case (state_q)
            ST_IDLE: begin
                if (start_ok) begin
                    state_d = ST_WAIT;
                    mem_req_d = 1'b1;
                    busy_d = 1'b1;
                    cycle_kind_d = cyc_sel;
                    mem_write_d = start_store;
                    if (start_fetch) begin
                        virt_addr_d = program_counter;
                        program_counter_d = program_counter + `PC_STEP;
                    end else begin
                        virt_addr_d = sum2;
                    end
                end
            end
            ST_WAIT: begin
                // Address latch holds for the whole request
                if (mem_done) begin
                    state_d = ST_IDLE;
                    mem_req_d = 1'b0;
                    mem_write_d = 1'b0;
                    busy_d = 1'b0;
                    cycle_kind_d = `CYC_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                mem_req_d = 1'b0;
                mem_write_d = 1'b0;
                busy_d = 1'b0;
                cycle_kind_d = `CYC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read data steering
    // ------------------------------------------------------------
    // Store ends leave both registers alone; no write data comes back
    always @* begin
        instr_reg_d = instr_reg;
        hold_reg_d = hold_reg;
        if (load_ir) begin
            instr_reg_d = mem_rdata;
        end
        if (load_hold) begin
            hold_reg_d = mem_rdata;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Every output is a flop so the memory side sees no decode glitches
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            virt_addr <= `RST_WORD;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            program_counter <= `RST_PC;
            instr_reg <= `RST_WORD;
            hold_reg <= `RST_WORD;
            cycle_kind <= `CYC_IDLE;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            virt_addr <= virt_addr_d;
            mem_req <= mem_req_d;
            mem_write <= mem_write_d;
            program_counter <= program_counter_d;
            instr_reg <= instr_reg_d;
            hold_reg <= hold_reg_d;
            cycle_kind <= cycle_kind_d;
            busy <= busy_d;
        end
    end
endmodule

/* design/addr_arith_map.vh */
// Field positions, cycle codes and reset values for the address arithmetic
`ifndef ADDR_ARITH_MAP_VH
`define ADDR_ARITH_MAP_VH
// Instruction word fields
`define IR_POST_X_BIT 10
`define IR_IND_BIT 9
`define IR_PRE_B_BIT 8
`define IR_DISP_MSB 7
`define IR_DISP_LSB 0
`define IR_DISP_SIGN 7
// Microinstruction cycle field
`define MIR_CYC_MSB 23
`define MIR_CYC_LSB 21
`define MIR_WIDTH 24
// Cycle codes in the microinstruction cycle field
`define CYC_IDLE 3'h0
`define CYC_FETCH 3'h1
`define CYC_OPREAD 3'h2
`define CYC_INDREAD 3'h3
`define CYC_STORE 3'h4
// Reset values and counter step
`define RST_WORD 16'h0000
`define RST_PC 16'h0000
`define PC_STEP 16'h0001
`endif

/* design/addr_adder.v */
// Selector-fed 16-bit adder stage of the address arithmetic
`timescale 1ns/1ps
module addr_adder (
    // Operands
    input wire [15:0] a,
    input wire [15:0] b,
    // Sum
    output wire [15:0] sum
);
    assign sum = a + b;
endmodule

/* dv/mem_partner.sv */
// Memory side model that answers each request after a set latency
`timescale 1ns/1ps
module mem_partner (
    input wire core_clk,
    input wire mem_req,
    input wire [1:0] lat,
    input wire [15:0] rdata_val,
    output reg mem_done,
    output wire [15:0] mem_rdata
);
    reg [2:0] cnt_q = 3'h0;
    initial mem_done = 1'b0;
    // Inverted data outside the done cycle, so a late sample shows up
    assign mem_rdata = mem_done ? rdata_val : ~rdata_val;
    always @(posedge core_clk) begin
        mem_done <= mem_req && !mem_done && cnt_q == {1'b0, lat};
        cnt_q <= (mem_req && !mem_done) ? cnt_q + 3'h1 : 3'h0;
    end
endmodule

/* dv/cpu_address_arithmetic_checker.sv */
// Port assertions for the address arithmetic
`timescale 1ns/1ps
module cpu_address_arithmetic_checker (
    // Control in
    input wire core_clk,
    input wire rst_n,
    input wire [23:0] microinstruction_register,
    input wire cycle_start,
    input wire mem_done,
    input wire [15:0] mem_rdata,
    // Outputs
    input wire [15:0] virt_addr,
    input wire mem_req,
    input wire mem_write,
    input wire [15:0] program_counter,
    input wire [15:0] instr_reg,
    input wire [15:0] hold_reg,
    input wire [2:0] cycle_kind,
    input wire busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [2:0] k = microinstruction_register[23:21];
    wire go = cycle_start && !busy;
    wire take = go && k >= 3'h1 && k <= 3'h4;
    wire fin = mem_req && mem_done;
    fetch_addr_a: assert property (go && k == 3'h1 |=> mem_req && virt_addr == $past(program_counter)
        && program_counter == virt_addr + 16'h1) else $error("fetch address or step wrong");
    cycle_kind_a: assert property (take |=> mem_req && cycle_kind == $past(k)) else $error("cycle kind wrong");
    idle_stay_a: assert property (!mem_req && !take |=> !mem_req) else $error("request without start");
    write_dir_a: assert property (mem_req |-> mem_write == (cycle_kind == 3'h4)) else $error("direction wrong");
    addr_hold_a: assert property (mem_req && !mem_done |=> mem_req && $stable(virt_addr)) else $error("addr moved");
    req_end_a: assert property (fin |=> !mem_req && cycle_kind == 3'h0) else $error("request not ended");
    fetch_load_a: assert property (fin && cycle_kind == 3'h1 |=> instr_reg == $past(mem_rdata)
        && hold_reg == $past(mem_rdata)) else $error("fetched word not loaded");
    ind_capture_a: assert property (fin && cycle_kind == 3'h3 |=> hold_reg == $past(mem_rdata))
        else $error("indirect word not held");
    busy_match_a: assert property (busy == mem_req) else $error("busy differs from request");
    cover property (take && k == 3'h3);
    cover property (take && k == 3'h4);
    cover property (fin && cycle_kind == 3'h1);
endmodule
bind cpu_address_arithmetic cpu_address_arithmetic_checker cpu_address_arithmetic_checker_i (.*);

/* dv/test_cpu_address_arithmetic.sv */
// Bench: addressing mode table, then refusal and reset cases
`timescale 1ns/1ps
module test_cpu_address_arithmetic;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [23:0] micro_word = 24'h0;
    reg cycle_start = 1'b0;
    reg [1:0] lat = 2'h0;
    reg [15:0] rdata_val = 16'h0;
    reg [15:0] x_val = 16'h0200;
    reg [15:0] b_val = 16'h1000;
    wire mem_done, mem_write, mem_req, busy;
    wire [15:0] mem_rdata, virt_addr, program_counter, instr_reg, hold_reg;
    wire [2:0] cycle_kind;
    // Row: instruction, operand cycle, indirect address, operand address
    reg [50:0] rows [0:5];
    reg [50:0] r;
    integer i, n, checked = 0, miscompares = 0;
    cpu_address_arithmetic cpu_address_arithmetic_i (.core_clk(core_clk), .rst_n(rst_n),
        .microinstruction_register(micro_word), .cycle_start(cycle_start), .index_reg(x_val),
        .base_reg(b_val), .mem_done(mem_done), .mem_rdata(mem_rdata), .virt_addr(virt_addr),
        .mem_req(mem_req), .mem_write(mem_write), .program_counter(program_counter),
        .instr_reg(instr_reg), .hold_reg(hold_reg), .cycle_kind(cycle_kind), .busy(busy));
    mem_partner mem_partner_i (.core_clk(core_clk), .mem_req(mem_req),
        .lat(lat), .rdata_val(rdata_val), .mem_done(mem_done), .mem_rdata(mem_rdata));
    initial forever #20 core_clk = ~core_clk;
    task chk(input [15:0] s, input [15:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, s, e);
            end
        end
    endtask
    task conclude;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task xfer(input [2:0] k, input [15:0] d, input [15:0] a);
        begin
            @(posedge core_clk);
            rdata_val <= d;
            micro_word <= {k, 21'h0};
            cycle_start <= 1'b1;
            @(posedge core_clk);
            cycle_start <= 1'b0;
            #1 chk(virt_addr, a);
            chk({15'h0, mem_write}, {15'h0, k == 3'h4});
            n = 0;
            while (mem_done !== 1'b1 && n < 9) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            chk({15'h0, mem_done}, 16'h1);
            @(posedge core_clk);
            #1 chk({15'h0, mem_req}, 16'h0);
        end
    endtask
    initial begin
        #100000 miscompares = miscompares + 1;
        conclude;
    end
    initial begin
        rows[0] = {16'h007f, 3'h2, 16'h0000, 16'h0080};
        rows[1] = {16'h0180, 3'h4, 16'h0000, 16'h0f80};
        rows[2] = {16'h0705, 3'h2, 16'h1005, 16'h3200};
        rows[3] = {16'h0281, 3'h4, 16'hff85, 16'h3000};
        rows[4] = {16'h04ff, 3'h2, 16'h0000, 16'h0204};
        rows[5] = {16'h0500, 3'h2, 16'h0000, 16'h1200};
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            r = rows[i];
            lat <= i[1:0];
            xfer(3'h1, r[50:35], i[15:0]);
            chk(instr_reg, r[50:35]);
            chk(hold_reg, r[50:35]);
            chk(program_counter, i[15:0] + 16'h1);
            if (r[44]) begin
                xfer(3'h3, 16'h3000, r[31:16]);
                chk(hold_reg, 16'h3000);
            end
            xfer(r[34:32], 16'h0, r[15:0]);
            $display("row %0d done", i);
        end
        // Start while busy is ignored; B and X are read on the start edge
        @(posedge core_clk);
        lat <= 2'h3;
        b_val <= 16'h2000;
        x_val <= 16'h0040;
        rdata_val <= 16'h5a5a;
        micro_word <= {3'h2, 21'h0};
        cycle_start <= 1'b1;
        @(posedge core_clk);
        micro_word <= {3'h1, 21'h0};
        @(posedge core_clk);
        cycle_start <= 1'b0;
        #1 chk(virt_addr, 16'h2040);
        chk(program_counter, 16'h0006);
        chk({13'h0, cycle_kind}, 16'h0002);
        repeat (4) @(posedge core_clk);
        #1 chk({15'h0, mem_req}, 16'h0);
        chk(hold_reg, 16'h5a5a);
        $display("busy refusal done");
        // Unused cycle code is ignored
        @(posedge core_clk);
        micro_word <= {3'h5, 21'h0};
        cycle_start <= 1'b1;
        @(posedge core_clk);
        cycle_start <= 1'b0;
        #1 chk({15'h0, mem_req}, 16'h0);
        rst_n <= 1'b0;
        #40 chk(program_counter, 16'h0);
        chk({15'h0, busy}, 16'h0);
        // Release in mid-run, then a fetch restarts from the reset counter
        @(posedge core_clk);
        rst_n <= 1'b1;
        lat <= 2'h0;
        xfer(3'h1, 16'h0181, 16'h0000);
        chk(program_counter, 16'h0001);
        chk(instr_reg, 16'h0181);
        $display("refusal and reset done");
        conclude;
    end
endmodule
